// ### include/psm_cfg.svh
`ifndef PSM_CFG_SVH
`define PSM_CFG_SVH
// coding-sublayer configuration register bit positions
`define PSM_CS_FIBER_BIT 6
`define PSM_CS_FEF_BIT 3
`define PSM_CS_SCR_BYP_BIT 1
`define PSM_CS_DESCR_BYP_BIT 0
`define PSM_CS_RESET 16'h0000
// basic mode control register bit positions
`define PSM_BMC_SPEED_BIT 13
`define PSM_BMC_NEG_EN_BIT 12
`define PSM_BMC_DUPLEX_BIT 8
`define PSM_BMC_RESET 16'h0000
// advertisement register technology field [8:5]
`define PSM_ADV_LSB 5
`define PSM_ADV_MSB 8
`define PSM_ADV_SEL_FIELD 16'h0001
// advertised ability encodings {100fd,100hd,10fd,10hd}
`define PSM_ABIL_10_BOTH 4'h3
`define PSM_ABIL_100_BOTH 4'hC
`define PSM_ABIL_HALF_ONLY 4'h5
`define PSM_ABIL_ALL 4'hF
`define PSM_PORTS 2
`endif

// ### include/psm_pkg.sv
package psm_pkg;
	typedef enum logic [3:0] {
		PSM_MODE_NONE = 4'h0,
		PSM_MODE_10HD = 4'h1,
		PSM_MODE_10FD = 4'h2,
		PSM_MODE_100HD = 4'h4,
		PSM_MODE_100FD = 4'h8
	} psm_mode_t;
	typedef enum logic [1:0] {
		PSM_ST_RESET = 2'h1,
		PSM_ST_RUN = 2'h2
	} psm_state_t;
endpackage

// ### include/psm_res_if.sv
`timescale 1ns/1ns
`default_nettype none
interface psm_res_if;
	logic [3:0] local_abil;
	logic [3:0] partner_abil;
	logic [3:0] common_mode;
	modport requester (output local_abil, output partner_abil, input common_mode);
	modport resolver (input local_abil, input partner_abil, output common_mode);
endinterface
`default_nettype wire

// ### logic/psm_resolve.sv
`timescale 1ns/1ns
`default_nettype none
module psm_resolve (
	psm_res_if.resolver res
);
	import psm_pkg::*;
	logic [3:0] both;
	assign both = res.local_abil & res.partner_abil;
	// fixed preference order, highest first
	always_comb begin
		if (both[3]) begin
			res.common_mode = PSM_MODE_100FD;
		end else if (both[2]) begin
			res.common_mode = PSM_MODE_100HD;
		end else if (both[1]) begin
			res.common_mode = PSM_MODE_10FD;
		end else if (both[0]) begin
			res.common_mode = PSM_MODE_10HD;
		end else begin
			res.common_mode = PSM_MODE_NONE;
		end
	end
endmodule
`default_nettype wire

// ### logic/psm_strap_mode_config.sv
// Operation
// - sample media strap at reset; high means fiber
// - fiber strap sets fault and scrambler bypasses
// - software write overrides fiber-enable bit
// - each port keeps its own media choice
// - straps load four advertised ability bits
// - negotiation strap low forces fixed mode
// - negotiation strap high picks advertised set
// - software may rewrite basic mode control
// - negotiation picks best commonly advertised mode
// - preference: 100FD, 100HD, 10FD, 10HD
// - speed/duplex bits ignored while negotiating
`timescale 1ns/1ns
`default_nettype none
`include "psm_cfg.svh"
module psm_strap_mode_config (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [1:0] media_strap,
	input wire logic [1:0] negotiation_enable_strap,
	input wire logic [1:0] mode_select_strap_hi,
	input wire logic [1:0] mode_select_strap_lo,
	input wire logic [1:0] cs_wr,
	input wire logic [15:0] cs_wdata,
	input wire logic [1:0] bmc_wr,
	input wire logic [15:0] bmc_wdata,
	input wire logic [1:0] adv_wr,
	input wire logic [15:0] adv_wdata,
	input wire logic [7:0] partner_abil,
	output logic [31:0] coding_sublayer_cfg,
	output logic [31:0] basic_mode_control,
	output logic [31:0] advertise,
	output logic [1:0] fiber_media,
	output logic [7:0] op_mode,
	output logic cfg_valid
);
	import psm_pkg::*;

	// ----------------------------------------
	// strap synchronisers
	// ----------------------------------------
	logic [7:0] strap_meta_reg;
	logic [7:0] strap_sync_reg;
	always_ff @(posedge sys_clk) begin
		strap_meta_reg <= {mode_select_strap_lo, mode_select_strap_hi, negotiation_enable_strap, media_strap};
		strap_sync_reg <= strap_meta_reg;
	end

	// ----------------------------------------
	// capture sequencing
	// ----------------------------------------
	psm_state_t state_reg;
	psm_state_t state_next;
	logic capture;
	// straps are loaded in the first cycle after release; the two-stage
	// synchroniser has settled by then only if reset spans two edges
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			PSM_ST_RESET: state_next = PSM_ST_RUN;
			PSM_ST_RUN: state_next = PSM_ST_RUN;
			default: state_next = PSM_ST_RESET;
		endcase
	end
	assign capture = (state_reg == PSM_ST_RESET);
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= PSM_ST_RESET;
		end else begin
			state_reg <= state_next;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cfg_valid <= 1'b0;
		end else begin
			cfg_valid <= capture | cfg_valid;
		end
	end

	// ----------------------------------------
	// per-port registers
	// ----------------------------------------
	logic [3:0] mode_now [`PSM_PORTS];
	genvar p;
	generate
		for (p = 0; p < `PSM_PORTS; p++) begin : g_port
			logic [15:0] cs_reg;
			logic [15:0] bmc_reg;
			logic [15:0] adv_reg;
			logic [15:0] cs_strap;
			logic [15:0] bmc_strap;
			logic [15:0] adv_strap;
			logic fib;
			logic neg;
			logic [1:0] sel;
			logic [3:0] abil;
			logic [3:0] forced;
			psm_res_if res ();
			assign fib = strap_sync_reg[p];
			assign neg = strap_sync_reg[2 + p];
			assign sel = {strap_sync_reg[4 + p], strap_sync_reg[6 + p]};
			always_comb begin
				cs_strap = `PSM_CS_RESET;
				if (fib) begin
					cs_strap[`PSM_CS_FIBER_BIT] = 1'b1;
					cs_strap[`PSM_CS_FEF_BIT] = 1'b1;
					cs_strap[`PSM_CS_SCR_BYP_BIT] = 1'b1;
					cs_strap[`PSM_CS_DESCR_BYP_BIT] = 1'b1;
				end
				unique case (sel)
					2'b00: abil = `PSM_ABIL_10_BOTH;
					2'b01: abil = `PSM_ABIL_100_BOTH;
					2'b10: abil = `PSM_ABIL_HALF_ONLY;
					2'b11: abil = `PSM_ABIL_ALL;
				endcase
				adv_strap = `PSM_ADV_SEL_FIELD;
				adv_strap[`PSM_ADV_MSB:`PSM_ADV_LSB] = abil;
				if (!neg) begin
					// forced mode also advertises only itself
					adv_strap[`PSM_ADV_MSB:`PSM_ADV_LSB] = 4'(4'h1 << sel);
				end
				bmc_strap = `PSM_BMC_RESET;
				bmc_strap[`PSM_BMC_NEG_EN_BIT] = neg;
				bmc_strap[`PSM_BMC_SPEED_BIT] = sel[1];
				bmc_strap[`PSM_BMC_DUPLEX_BIT] = sel[0];
			end
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					cs_reg <= `PSM_CS_RESET;
				end else if (capture) begin
					cs_reg <= cs_strap;
				end else if (cs_wr[p]) begin
					cs_reg <= cs_wdata;
				end
			end
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					bmc_reg <= `PSM_BMC_RESET;
				end else if (capture) begin
					bmc_reg <= bmc_strap;
				end else if (bmc_wr[p]) begin
					bmc_reg <= bmc_wdata;
				end
			end
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					adv_reg <= `PSM_ADV_SEL_FIELD;
				end else if (capture) begin
					adv_reg <= adv_strap;
				end else if (adv_wr[p]) begin
					adv_reg <= adv_wdata;
				end
			end
			assign res.local_abil = adv_reg[`PSM_ADV_MSB:`PSM_ADV_LSB];
			assign res.partner_abil = partner_abil[4 * p +: 4];
			psm_resolve u_res (
				.res(res.resolver)
			);
			always_comb begin
				forced = 4'(4'h1 << {bmc_reg[`PSM_BMC_SPEED_BIT], bmc_reg[`PSM_BMC_DUPLEX_BIT]});
				if (bmc_reg[`PSM_BMC_NEG_EN_BIT]) begin
					mode_now[p] = res.common_mode;
				end else begin
					mode_now[p] = forced;
				end
			end
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					coding_sublayer_cfg[16 * p +: 16] <= `PSM_CS_RESET;
					basic_mode_control[16 * p +: 16] <= `PSM_BMC_RESET;
					advertise[16 * p +: 16] <= `PSM_ADV_SEL_FIELD;
					fiber_media[p] <= 1'b0;
					op_mode[4 * p +: 4] <= PSM_MODE_NONE;
				end else begin
					coding_sublayer_cfg[16 * p +: 16] <= cs_reg;
					basic_mode_control[16 * p +: 16] <= bmc_reg;
					advertise[16 * p +: 16] <= adv_reg;
					fiber_media[p] <= cs_reg[`PSM_CS_FIBER_BIT];
					op_mode[4 * p +: 4] <= mode_now[p];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ### testbench/psm_checker.sv
`timescale 1ns/1ns
`default_nettype none
module psm_checker (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [1:0] media_strap,
	input wire logic [1:0] negotiation_enable_strap,
	input wire logic [1:0] mode_select_strap_hi,
	input wire logic [1:0] mode_select_strap_lo,
	input wire logic [1:0] cs_wr,
	input wire logic [15:0] cs_wdata,
	input wire logic [7:0] partner_abil,
	input wire logic [31:0] coding_sublayer_cfg,
	input wire logic [31:0] basic_mode_control,
	input wire logic [31:0] advertise,
	input wire logic [1:0] fiber_media,
	input wire logic [7:0] op_mode,
	input wire logic cfg_valid
);
	wire logic [1:0] sa = {mode_select_strap_hi[0], mode_select_strap_lo[0]};
	wire logic [1:0] sb = {mode_select_strap_hi[1], mode_select_strap_lo[1]};
	function automatic logic [3:0] adv(input logic n, input logic [1:0] s);
		adv = n ? {s[0], |s, ~^s, s[1] | !s[0]} : 4'h1 << s;
	endfunction
	function automatic logic [3:0] best(input logic [3:0] a);
		best = a[3] ? 4'h8 : a[2] ? 4'h4 : a[1] ? 4'h2 : {3'h0, a[0]};
	endfunction
	// ---
	// checks
	// ---
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_strap_media: assert property (
		$fell(rst) |-> ##3 fiber_media == media_strap && {coding_sublayer_cfg[19:16], coding_sublayer_cfg[3:0]}
		== {media_strap[1] ? 4'hB : 4'h0, media_strap[0] ? 4'hB : 4'h0}) else $error("media strap not captured");
	a_adv_strap: assert property (
		$fell(rst) |-> ##3 {advertise[24:21], advertise[8:5]}
		== {adv(negotiation_enable_strap[1], sb), adv(negotiation_enable_strap[0], sa)}) else $error("bad abilities");
	a_bmc_strap: assert property (
		$fell(rst) |-> ##3 basic_mode_control[15:0]
		== {2'h0, sa[1], negotiation_enable_strap[0], 3'h0, sa[0], 8'h00}) else $error("bad mode");
	a_fiber_bit: assert property (
		fiber_media == {coding_sublayer_cfg[22], coding_sublayer_cfg[6]}) else $error("fiber flag off bit");
	a_cs_write: assert property (
		$past(cfg_valid) && cs_wr[0] ##1 !cs_wr[0] |=> coding_sublayer_cfg[15:0] == $past(cs_wdata, 2))
		else $error("write lost");
	a_forced_op: assert property (
		$past(cfg_valid) && !basic_mode_control[12]
		|-> op_mode[3:0] == 4'h1 << {basic_mode_control[13], basic_mode_control[8]}) else $error("forced mode");
	a_neg_best: assert property (
		$past(cfg_valid) && basic_mode_control[28] && partner_abil == $past(partner_abil, 2)
		|-> op_mode[7:4] == best(advertise[24:21] & partner_abil[7:4])) else $error("not best common mode");
	a_valid_hold: assert property (cfg_valid |=> cfg_valid) else $error("valid dropped");
	c_release: cover property ($fell(rst));
	c_cs_write: cover property (cs_wr[0]);
	c_negotiate: cover property (basic_mode_control[28] && op_mode[7:4] == 4'h1);
endmodule
bind psm_strap_mode_config psm_checker i_chk (.sys_clk, .rst, .media_strap, .negotiation_enable_strap,
	.mode_select_strap_hi, .mode_select_strap_lo, .cs_wr, .cs_wdata, .partner_abil, .coding_sublayer_cfg,
	.basic_mode_control, .advertise, .fiber_media, .op_mode, .cfg_valid);
`default_nettype wire

// ### testbench/psm_link_partner.sv
`timescale 1ns/1ns
`default_nettype none
module psm_link_partner (
	input wire logic sys_clk,
	input wire logic [7:0] abil_set,
	output logic [7:0] partner_abil
);
	// far-end abilities, launched from the local clock so no resync is needed
	always_ff @(posedge sys_clk) begin
		partner_abil <= abil_set;
	end
endmodule
`default_nettype wire

// ### testbench/psm_strap_mode_config_tb.sv
`timescale 1ns/1ns
`default_nettype none
module psm_strap_mode_config_tb;
	logic sys_clk = 0, rst = 1, v;
	logic [1:0] ms = '0, ne = '0, sh = '0, sl = '0, cw = '0, bw = '0, aw = '0, fm;
	logic [15:0] cd = '0, bd = '0, ad = '0;
	logic [7:0] pa = 8'h7F, pab, op;
	logic [31:0] cs, bmc, adv;
	int err_count = 0, n_compared = 0;
	always #10 sys_clk = ~sys_clk;
	psm_link_partner i_lp (.sys_clk, .abil_set(pa), .partner_abil(pab));
	psm_strap_mode_config i_dut (.sys_clk, .rst, .media_strap(ms), .negotiation_enable_strap(ne),
		.mode_select_strap_hi(sh), .mode_select_strap_lo(sl), .cs_wr(cw), .cs_wdata(cd), .bmc_wr(bw),
		.bmc_wdata(bd), .adv_wr(aw), .adv_wdata(ad), .partner_abil(pab), .coding_sublayer_cfg(cs),
		.basic_mode_control(bmc), .advertise(adv), .fiber_media(fm), .op_mode(op), .cfg_valid(v));
	task automatic cmp(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [1:0] c, b, a, input logic [15:0] d);
		{cw, bw, aw, cd, bd, ad} = {c, b, a, d, d, d};
		@(negedge sys_clk);
		{cw, bw, aw} = '0;
		repeat (3) @(negedge sys_clk);
	endtask
	// ---
	// scenarios
	// ---
	// outputs lag the internal registers by one edge, so the strapped
	// values appear one cycle after cfg_valid
	task automatic t_reset;
		cmp("adv", 32'h0001_0001, adv);
		cmp("valid", 32'h0, v);
		rst = 0;
		@(negedge sys_clk);
		cmp("valid", 32'h1, v);
		cmp("adv", 32'h0001_0001, adv);
		@(negedge sys_clk);
		cmp("adv", 32'h0021_0021, adv);
		cmp("op", 32'h11, op);
		$display("test reset done");
	endtask
	task automatic t_straps;
		logic [3:0] eb;
		logic [3:0] tb[4] = '{4'h3, 4'hC, 4'h5, 4'hF};
		logic [3:0] nb[4] = '{4'h2, 4'h4, 4'h4, 4'h4};
		for (int k = 0; k < 8; k++) begin
			{ne, sh, sl, ms} = {k[2], 1'b0, k[1], 1'b1, k[0], 1'b1, k[0], 1'b1};
			rst = 1;
			repeat (3) @(negedge sys_clk);
			rst = 0;
			repeat (4) @(negedge sys_clk);
			eb = k[2] ? tb[k[1:0]] : 4'h1 << k[1:0];
			cmp("adv", {7'h0, eb, 5'h01, 7'h0, 4'h8, 5'h01}, adv);
			cmp("cs", {k[0] ? 16'h004B : 16'h0000, 16'h004B}, cs);
			cmp("fiber", {k[0], 1'b1}, fm);
			cmp("bmc", {2'h0, k[1], k[2], 3'h0, k[0], 8'h00, 16'h2100}, bmc);
			cmp("op", {k[2] ? nb[k[1:0]] : eb, 4'h8}, op);
		end
		ms = 2'h0;
		ne = 2'h3;
		repeat (4) @(negedge sys_clk);
		cmp("held", {16'h004B, 16'h004B}, cs);
		$display("test straps done");
	endtask
	task automatic t_sw;
		wr(2'h1, 2'h0, 2'h0, 16'h0000);
		cmp("fiber", 2'h2, fm);
		wr(2'h0, 2'h2, 2'h0, 16'h0100);
		cmp("bmc", 16'h0100, bmc[31:16]);
		cmp("op", 4'h2, op[7:4]);
		// speed and duplex bits set here must not matter while negotiating
		wr(2'h0, 2'h2, 2'h2, 16'h3121);
		cmp("op", 4'h1, op[7:4]);
		pa = 8'hFF;
		repeat (3) @(negedge sys_clk);
		cmp("op", 4'h8, op[7:4]);
		$display("test software done");
	endtask
	initial begin
		repeat (12) @(negedge sys_clk);
		t_reset;
		t_straps;
		t_sw;
		stop_test;
	end
	initial begin
		#100000;
		err_count++;
		stop_test;
	end
endmodule
`default_nettype wire
